// file: wdt_pkg.sv
// package: register layout, timing constants and types for the watchdog control block
// How it works
// - on time-out with interrupt behaviour configured, set flag bit 7.
// - flag clears when the core executes the watchdog vector.
// - writing one to the flag clears it; writing zero leaves it.
// - interrupt request only when flag, enable bit 6 and global enable are set.
// - enable set, reset enable clear: interrupt on each time-out, never reset.
// - both enables set: first time-out only sets the flag.
// - in combined mode the vector clears interrupt enable and flag.
// - combined mode, unserviced flag at next time-out gives system reset.
// - clearing reset enable or changing prescaler needs change-unlock bit 4 set.
// - change-unlock self-clears four system clock cycles after being written one.
// - while the reset-cause flag is set, reset enable reads and acts as one.
// - prescaler is bits 5 and 2..0, bit 5 most significant.
// - codes 0 to 9 give 2048 doubling to 1048576 cycles; others reserved.
// - always-on fuse forces reset-only mode, enables locked to one and zero.
// - count a separate 128 kHz oscillator; restart instruction restarts the count.
// - every watchdog system reset sets the reset-cause flag.
package wdt_pkg;
    // register index and bit positions
    localparam logic [1:0] CSR_ADDR = 2'h0;
    localparam logic [1:0] CAUSE_ADDR = 2'h1;
    localparam int BIT_IRQ_FLAG = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_SEL_HI = 5;
    localparam int BIT_UNLOCK = 4;
    localparam int BIT_RST_EN = 3;
    localparam int BIT_CAUSE = 3;
    // reset values
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic RST_EN_RESET = 1'b0;
    // timing
    localparam int UNLOCK_CYCLES = 4;
    localparam int OSC_KHZ = 128;
    localparam int CORE_KHZ = 40000;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam int BASE_CYCLES = 2048;
    localparam int CNT_W = 21;

    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_IRQ = 2'b01,
        MODE_RST = 2'b10,
        MODE_BOTH = 2'b11
    } mode_t;

    // core-side register port carried as one bundle
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// file: wdt_counter.sv
// module: oscillator-cycle counter that signals a time-out at the selected length
`timescale 1ns/1ps
module wdt_counter
    import wdt_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // control
    input wire logic i_run,
    input wire logic i_osc_tick,
    input wire logic i_restart,
    input wire logic [3:0] i_sel,
    // event
    output logic o_timeout
);
    logic [W-1:0] count_reg;
    logic [W-1:0] limit;

    // terminal count from prescaler code, reserved codes act as longest
    always_comb begin
        if (i_sel > SEL_MAX) begin
            limit = W'(BASE_CYCLES) << SEL_MAX;
        end else begin
            limit = W'(BASE_CYCLES) << i_sel;
        end
    end

    // count oscillator ticks; restart or stop clears the count
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            count_reg <= '0;
            o_timeout <= 1'b0;
        end else begin
            o_timeout <= 1'b0;
            if (!i_run || i_restart) begin
                count_reg <= '0;
            end else if (i_osc_tick) begin
                if (count_reg >= limit - W'(1)) begin
                    count_reg <= '0;
                    o_timeout <= 1'b1;
                end else begin
                    count_reg <= count_reg + W'(1);
                end
            end
        end
    end

    a_timeout_cause: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_timeout |-> $past(i_osc_tick) && $past(i_run))
        else $error("time-out without oscillator tick");
endmodule

// file: wdt_ctrl.sv
// module: watchdog control/status register, mode logic and reset-cause flag
`timescale 1ns/1ps
module wdt_ctrl
    import wdt_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // register port
    input wire reg_req_t i_req,
    output logic [7:0] o_rdata,
    // core events
    input wire logic i_global_irq_en,
    input wire logic i_vector_taken,
    input wire logic i_wdr,
    // oscillator and fuse
    input wire logic i_osc_tick,
    input wire logic i_always_on_fuse,
    // outputs to the system
    output logic o_irq_req,
    output logic o_sys_reset
);
    logic timeout_irq_flag_reg;
    logic timeout_irq_enable_reg;
    logic reset_on_timeout_enable_reg;
    logic change_unlock_reg;
    logic [2:0] unlock_cnt_reg;
    logic [3:0] timeout_select_reg;
    logic wd_reset_cause_flag_reg;
    logic timeout;
    logic rst_en_eff;
    logic irq_en_eff;
    logic wr_csr;
    logic wr_cause;
    logic do_reset;
    mode_t mode;

    // write decode shared by both registers
    function automatic logic hit(input reg_req_t r, input logic [1:0] a);
        return r.wr && (r.addr == a);
    endfunction

    assign wr_csr = hit(i_req, CSR_ADDR);
    assign wr_cause = hit(i_req, CAUSE_ADDR);

    // effective enables after fuse and cause-flag overrides
    assign rst_en_eff = reset_on_timeout_enable_reg || wd_reset_cause_flag_reg
                        || i_always_on_fuse;
    assign irq_en_eff = timeout_irq_enable_reg && !i_always_on_fuse;
    assign mode = mode_t'({rst_en_eff, irq_en_eff});

    wdt_counter #(.W(CNT_W)) u_counter (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_run(mode != MODE_STOP),
        .i_osc_tick(i_osc_tick),
        .i_restart(i_wdr),
        .i_sel(timeout_select_reg),
        .o_timeout(timeout)
    );

    // time-out action per mode
    always_comb begin
        do_reset = 1'b0;
        unique case (mode)
            MODE_STOP: do_reset = 1'b0;
            MODE_IRQ: do_reset = 1'b0;
            MODE_RST: do_reset = timeout;
            MODE_BOTH: do_reset = timeout && timeout_irq_flag_reg;
        endcase
    end

    // system reset pulse
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sys_reset <= 1'b0;
        end else begin
            o_sys_reset <= do_reset;
        end
    end

    // interrupt flag: set wins over clear
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            timeout_irq_flag_reg <= 1'b0;
        end else if (timeout && irq_en_eff) begin
            timeout_irq_flag_reg <= 1'b1;
        end else if (i_vector_taken) begin
            timeout_irq_flag_reg <= 1'b0;
        end else if (wr_csr && i_req.wdata[BIT_IRQ_FLAG]) begin
            timeout_irq_flag_reg <= 1'b0;
        end
    end

    // interrupt enable, cleared by the vector in combined mode
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            timeout_irq_enable_reg <= 1'b0;
        end else if (wr_csr) begin
            timeout_irq_enable_reg <= i_req.wdata[BIT_IRQ_EN];
        end else if (i_vector_taken && mode == MODE_BOTH) begin
            timeout_irq_enable_reg <= 1'b0;
        end
    end

    // change-unlock bit and its four-cycle window
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            change_unlock_reg <= 1'b0;
            unlock_cnt_reg <= 3'h0;
        end else if (wr_csr && i_req.wdata[BIT_UNLOCK]) begin
            change_unlock_reg <= 1'b1;
            unlock_cnt_reg <= 3'(UNLOCK_CYCLES - 1);
        end else if (change_unlock_reg) begin
            if (unlock_cnt_reg == 3'h0) begin
                change_unlock_reg <= 1'b0;
            end else begin
                unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
            end
        end
    end

    // reset enable clearing and prescaler, guarded by change-unlock
    // a pending reset cause pins the stored enable, so it survives the cause being cleared later
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            reset_on_timeout_enable_reg <= RST_EN_RESET;
            timeout_select_reg <= SEL_RESET;
        end else if (wr_csr) begin
            if (i_req.wdata[BIT_RST_EN]) begin
                reset_on_timeout_enable_reg <= 1'b1;
            end else if (change_unlock_reg && !wd_reset_cause_flag_reg) begin
                reset_on_timeout_enable_reg <= 1'b0;
            end
            if (change_unlock_reg) begin
                timeout_select_reg <= {i_req.wdata[BIT_SEL_HI], i_req.wdata[2:0]};
            end
        end
    end

    // reset-cause flag: set by watchdog reset, cleared by writing zero
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            wd_reset_cause_flag_reg <= 1'b0;
        end else if (do_reset) begin
            wd_reset_cause_flag_reg <= 1'b1;
        end else if (wr_cause && !i_req.wdata[BIT_CAUSE]) begin
            wd_reset_cause_flag_reg <= 1'b0;
        end
    end

    // interrupt request
    assign o_irq_req = timeout_irq_flag_reg && irq_en_eff && i_global_irq_en;

    // read data one cycle after the strobe
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd && i_req.addr == CSR_ADDR) begin
            o_rdata <= {timeout_irq_flag_reg, irq_en_eff, timeout_select_reg[3],
                        change_unlock_reg, rst_en_eff, timeout_select_reg[2:0]};
        end else if (i_req.rd && i_req.addr == CAUSE_ADDR) begin
            o_rdata <= {4'h0, wd_reset_cause_flag_reg, 3'h0};
        end else begin
            o_rdata <= 8'h00;
        end
    end

    a_flag_on_timeout: assert property (@(posedge i_core_clk) disable iff (i_reset)
        timeout && irq_en_eff |=> timeout_irq_flag_reg)
        else $error("flag not set on time-out");
    a_flag_write_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_csr && i_req.wdata[BIT_IRQ_FLAG] && !timeout |=> !timeout_irq_flag_reg)
        else $error("flag not cleared by write one");
    a_vector_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_vector_taken && !timeout |=> !timeout_irq_flag_reg)
        else $error("flag not cleared by vector");
    a_irq_gate: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_irq_req |-> timeout_irq_flag_reg && i_global_irq_en && timeout_irq_enable_reg)
        else $error("interrupt request without enables");
    a_irq_mode_noreset: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode == MODE_IRQ && timeout |=> !o_sys_reset)
        else $error("reset in interrupt-only mode");
    a_first_timeout: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode == MODE_BOTH && timeout && !timeout_irq_flag_reg |=> !o_sys_reset)
        else $error("reset on first combined time-out");
    a_second_timeout: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode == MODE_BOTH && timeout && timeout_irq_flag_reg |=> o_sys_reset)
        else $error("no reset on unserviced time-out");
    a_unlock_expiry: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_csr && i_req.wdata[BIT_UNLOCK] ##1 !wr_csr [*4] |=> !change_unlock_reg)
        else $error("change-unlock did not expire");
    a_locked_select: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !change_unlock_reg |=> $stable(timeout_select_reg))
        else $error("prescaler changed without unlock");
    a_cause_forces: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wd_reset_cause_flag_reg |-> rst_en_eff)
        else $error("reset enable not forced");
    a_fuse_lock: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_always_on_fuse |-> mode == MODE_RST)
        else $error("fuse did not force reset mode");
    a_cause_set: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_sys_reset |-> wd_reset_cause_flag_reg)
        else $error("reset-cause flag not set");
    a_unlock_window: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_csr && i_req.wdata[BIT_UNLOCK] |=> change_unlock_reg [*4])
        else $error("change-unlock left early");
    a_rst_en_held: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wd_reset_cause_flag_reg && reset_on_timeout_enable_reg |=> reset_on_timeout_enable_reg)
        else $error("reset enable cleared under reset cause");
    a_stop_quiet: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode == MODE_STOP |=> !timeout)
        else $error("time-out while stopped");
    a_rst_mode_reset: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode == MODE_RST && timeout |=> o_sys_reset)
        else $error("no reset in reset-only mode");
    a_sel_load: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_csr && change_unlock_reg |=> timeout_select_reg[3] == $past(i_req.wdata[BIT_SEL_HI]))
        else $error("prescaler high bit not loaded");
    a_vector_drops_en: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_vector_taken && mode == MODE_BOTH && !wr_csr |=> !timeout_irq_enable_reg)
        else $error("interrupt enable kept after vector");
    a_rst_en_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_csr && i_req.wdata[BIT_RST_EN] |=> rst_en_eff)
        else $error("reset enable write lost");
    a_cause_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
        wr_cause && !i_req.wdata[BIT_CAUSE] && !do_reset |=> !wd_reset_cause_flag_reg)
        else $error("reset-cause flag not cleared");

    c_irq_mode: cover property (@(posedge i_core_clk) mode == MODE_IRQ && timeout);
    c_both_reset: cover property (@(posedge i_core_clk) mode == MODE_BOTH && do_reset);
    c_unlock_clear: cover property (@(posedge i_core_clk)
        change_unlock_reg && wr_csr && !i_req.wdata[BIT_RST_EN]);
    c_rst_mode_reset: cover property (@(posedge i_core_clk) mode == MODE_RST && do_reset);
    c_vector_both: cover property (@(posedge i_core_clk) i_vector_taken && mode == MODE_BOTH);
endmodule

// file: core_model.sv
// partner model: processor core that answers the watchdog interrupt by taking its vector
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // interrupt handshake
    input wire logic i_irq_req,
    input wire logic i_service_en,
    input wire logic [7:0] i_latency,
    output logic o_vector_taken
);
    logic [7:0] wait_reg;

    // wait the chosen latency while the request stands, then take the vector once
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            wait_reg <= 8'h00;
            o_vector_taken <= 1'b0;
        end else begin
            o_vector_taken <= 1'b0;
            if (!i_irq_req || !i_service_en || o_vector_taken) begin
                wait_reg <= 8'h00;
            end else if (wait_reg == i_latency) begin
                o_vector_taken <= 1'b1;
                wait_reg <= 8'h00;
            end else begin
                wait_reg <= wait_reg + 8'h01;
            end
        end
    end
endmodule

// file: wdt_ctrl_tb.sv
// testbench: software sequences against the watchdog control block
`timescale 1ns/1ps
module wdt_ctrl_tb;
    import wdt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [7:0] lat = 8'h00;
    logic gie = 1'b1;
    logic wdr = 1'b0;
    logic tick = 1'b1;
    logic fuse = 1'b0;
    logic svc = 1'b0;
    logic vec;
    logic irq;
    logic sysrst;
    int n_errors = 0;
    int total_checks = 0;
    int n_resets = 0;
    int cycles = 0;

    wdt_ctrl u_wdt_ctrl (.i_core_clk(clk), .i_reset(rst), .i_req(req), .o_rdata(rdata),
        .i_global_irq_en(gie), .i_vector_taken(vec), .i_wdr(wdr), .i_osc_tick(tick),
        .i_always_on_fuse(fuse), .o_irq_req(irq), .o_sys_reset(sysrst));
    core_model u_core_model (.i_core_clk(clk), .i_reset(rst), .i_irq_req(irq), .i_service_en(svc),
        .i_latency(lat), .o_vector_taken(vec));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // count reset pulses and cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (sysrst === 1'b1) n_resets++;
        if (cycles == 60000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic poll(output logic [7:0] d);
        int n = 0;
        d = 8'h00;
        while (d[7] !== 1'b1 && n < 1500) begin
            rd(CSR_ADDR, d);
            n++;
        end
    endtask

    task automatic wait_reset();
        int start = n_resets;
        int n = 0;
        while (n_resets == start && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic restart();
        @(posedge clk);
        wdr <= 1'b1;
        @(posedge clk);
        wdr <= 1'b0;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped index, stopped mode
        rd(CSR_ADDR, v); check(v, 8'h00);
        rd(CAUSE_ADDR, v); check(v, 8'h00);
        wr(2'h3, 8'hFF); rd(2'h3, v); check(v, 8'h00);
        idle(2100); rd(CSR_ADDR, v); check(v, 8'h00);
        check(8'(n_resets), 8'h00);
        $display("test stopped mode done");
        // interrupt-only mode, time-out length, flag clearing
        wr(CSR_ADDR, 8'h40); idle(2030);
        rd(CSR_ADDR, v); check(v, 8'h40);
        poll(v); check(v, 8'hC0);
        check({7'h00, irq}, 8'h01);
        @(posedge clk); gie <= 1'b0;
        #1 check({7'h00, irq}, 8'h00);
        gie <= 1'b1;
        wr(CSR_ADDR, 8'h40); rd(CSR_ADDR, v); check(v, 8'hC0);
        wr(CSR_ADDR, 8'hC0); rd(CSR_ADDR, v); check(v, 8'h40);
        lat <= 8'h05; svc <= 1'b1;
        poll(v); check(v, 8'hC0);
        idle(10); rd(CSR_ADDR, v); check(v, 8'h40);
        check(8'(n_resets), 8'h00);
        svc <= 1'b0;
        $display("test interrupt mode done");
        // combined mode, unserviced then serviced
        wr(CSR_ADDR, 8'hC8); restart();
        poll(v); check(v, 8'hC8);
        check(8'(n_resets), 8'h00);
        wait_reset(); check(8'(n_resets), 8'h01);
        rd(CAUSE_ADDR, v); check(v, 8'h08);
        wr(CSR_ADDR, 8'hC8); lat <= 8'hC8; svc <= 1'b1;
        poll(v); check(v, 8'hC8);
        idle(300); rd(CSR_ADDR, v); check(v, 8'h08);
        svc <= 1'b0;
        wait_reset(); check(8'(n_resets), 8'h02);
        $display("test combined mode done");
        // change protection and unlock window
        wr(CSR_ADDR, 8'h18); wr(CSR_ADDR, 8'h00); idle(2); rd(CSR_ADDR, v); check(v, 8'h08);
        wr(CAUSE_ADDR, 8'h00); rd(CAUSE_ADDR, v); check(v, 8'h00);
        wr(CSR_ADDR, 8'h00); rd(CSR_ADDR, v); check(v, 8'h08);
        wr(CSR_ADDR, 8'h18); rd(CSR_ADDR, v); check(v, 8'h18);
        idle(3); rd(CSR_ADDR, v); check(v, 8'h08);
        wr(CSR_ADDR, 8'h18); idle(2); wr(CSR_ADDR, 8'h21); rd(CSR_ADDR, v); check(v, 8'h21);
        wr(CSR_ADDR, 8'h39); idle(3); wr(CSR_ADDR, 8'h00); rd(CSR_ADDR, v); check(v, 8'h29);
        $display("test unlock done");
        // restart instruction holds off the reset
        wr(CSR_ADDR, 8'h39); wr(CSR_ADDR, 8'h08);
        repeat (3) begin
            idle(1500); restart();
        end
        check(8'(n_resets), 8'h02);
        $display("test restart done");
        // always-on fuse forces reset-only mode
        @(posedge clk); fuse <= 1'b1;
        wr(CSR_ADDR, 8'h40); rd(CSR_ADDR, v); check(v, 8'h08);
        wr(CSR_ADDR, 8'h18); wr(CSR_ADDR, 8'h00); idle(2); rd(CSR_ADDR, v); check(v, 8'h08);
        wait_reset(); check(8'(n_resets), 8'h03);
        $display("test fuse done");
        tally_and_finish();
    end
endmodule
